//--- rtl/bcdx_exec.sv
// Purpose: execution datapath for compare-increment-branch, decimal adjust, decrement
// Assumes: decoder presents operands already fetched; start is a one-cycle pulse
// Notes: holds busy for the documented cycle count less the start cycle, results on done
`timescale 1ns/1ps
`include "bcdx_cfg.svh"
module bcdx_exec
	import bcdx_pkg::*;
(
	input wire logic clk,
	input wire logic rst,
	input wire logic start,
	input wire bcdx_req_t req,
	output logic busy,
	output logic done,
	output logic illegal,
	output bcdx_res_t res
);
	bcdx_state_t state;
	bcdx_state_t next_state;
	logic [4:0] count;
	logic [4:0] next_count;
	bcdx_res_t next_res;
	logic next_illegal;
	logic [7:0] da_value;
	logic da_carry;
	logic [7:0] diff;
	logic [7:0] dec_value;
	logic take;
	logic [15:0] pc_after;
	logic [7:0] fl;

	// Z and S from a result byte; used by both flag-writing paths
	function automatic logic [1:0] bcdx_zs(input logic [7:0] v);
		bcdx_zs = {v == 8'h00, v[7]};
	endfunction

	bcdx_decadj i_bcdx_decadj (
		.value(req.dst),
		.carry_in(req.flags[`BCDX_FLAG_C]),
		.half_in(req.flags[`BCDX_FLAG_H]),
		.sub_mode(req.sub_before),
		.result(da_value),
		.carry_out(da_carry)
	);

	// Datapath terms, sampled only on start
	always_comb
	begin
		diff = req.dst - req.src;
		take = (req.opcode == `BCDX_OP_CPIBE) ? (diff == 8'h00) : (diff != 8'h00);
		pc_after = req.pc + `BCDX_LEN_BRANCH;
		dec_value = req.dst - 8'h01;
	end

	// Sequencer and result computation
	always_comb
	begin
		next_state = state;
		next_count = count;
		next_res = res;
		next_illegal = 1'b0;
		fl = req.flags;
		case (state)
			BCDX_IDLE:
			begin
				if (start)
				begin
					next_state = BCDX_BUSY;
					next_res = '0;
					next_res.flags = req.flags;
					next_res.pc = req.pc;
					case (req.opcode)
						`BCDX_OP_CPIBE, `BCDX_OP_CPIBU:
						begin
							next_res.ptr_data = req.ptr + 8'h01;
							next_res.ptr_we = 1'b1;
							next_res.flags_we = 1'b0;
							next_res.pc = take ? pc_after + {{8{req.offset[7]}}, req.offset}
								: pc_after;
							next_count = take ? `BCDX_CYC_TAKEN : `BCDX_CYC_FALL;
						end
						`BCDX_OP_DA_R, `BCDX_OP_DA_IR:
						begin
							next_res.dst_data = da_value;
							next_res.dst_we = 1'b1;
							// carry, zero, sign; V left as is
							fl[`BCDX_FLAG_C] = da_carry;
							{fl[`BCDX_FLAG_Z], fl[`BCDX_FLAG_S]} = bcdx_zs(da_value);
							next_res.flags = fl;
							next_res.flags_we = 1'b1;
							next_count = `BCDX_CYC_SHORT;
						end
						`BCDX_OP_DEC_R, `BCDX_OP_DEC_IR:
						begin
							next_res.dst_data = dec_value;
							next_res.dst_we = 1'b1;
							// overflow only from 80 to 7f
							{fl[`BCDX_FLAG_Z], fl[`BCDX_FLAG_S]} = bcdx_zs(dec_value);
							fl[`BCDX_FLAG_V] = (req.dst == 8'h80);
							next_res.flags = fl;
							next_res.flags_we = 1'b1;
							next_count = `BCDX_CYC_SHORT;
						end
						default:
						begin
							// Foreign opcode: refuse without side effects
							// Last result stays visible, a refused start is not accepted
							next_res = res;
							next_state = BCDX_IDLE;
							next_illegal = 1'b1;
						end
					endcase
				end
			end
			BCDX_BUSY:
			begin
				next_count = count - 5'h01;
				// Count includes the start cycle and the done cycle
				// done lands in cycle N-1 after the start edge
				if (count == 5'h03)
					next_state = BCDX_DONE;
			end
			BCDX_DONE:
			begin
				next_state = BCDX_IDLE;
				next_count = 5'h00;
			end
			default:
			begin
				next_state = BCDX_IDLE;
				next_count = 5'h00;
			end
		endcase
	end

	// State registers
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			state <= BCDX_IDLE;
			count <= 5'h00;
			res <= '0;
			illegal <= 1'b0;
		end
		else
		begin
			state <= next_state;
			count <= next_count;
			res <= next_res;
			illegal <= next_illegal;
		end
	end

	// Handshake outputs, combinational from state
	assign busy = (state != BCDX_IDLE);
	assign done = (state == BCDX_DONE);
endmodule

//--- rtl/bcdx_cfg.svh
// Purpose: constants for the compare/branch, decimal adjust and decrement unit
// Assumes: included by the design modules bcdx_exec and bcdx_decadj
// Notes: opcodes and cycle counts as used by the execution sequencer
`ifndef BCDX_CFG_SVH
`define BCDX_CFG_SVH
`define BCDX_OP_DEC_R 8'h00
`define BCDX_OP_DEC_IR 8'h01
`define BCDX_OP_DA_R 8'h40
`define BCDX_OP_DA_IR 8'h41
`define BCDX_OP_CPIBE 8'hc2
`define BCDX_OP_CPIBU 8'hd2
`define BCDX_CYC_TAKEN 5'h12
`define BCDX_CYC_FALL 5'h10
`define BCDX_CYC_SHORT 5'h04
`define BCDX_LEN_BRANCH 16'h0003
`define BCDX_FLAG_C 7
`define BCDX_FLAG_Z 6
`define BCDX_FLAG_S 5
`define BCDX_FLAG_V 4
`define BCDX_FLAG_D 3
`define BCDX_FLAG_H 2
`define BCDX_ADD_06 8'h06
`define BCDX_ADD_60 8'h60
`define BCDX_ADD_66 8'h66
`define BCDX_SUB_FA 8'hfa
`define BCDX_SUB_A0 8'ha0
`define BCDX_SUB_9A 8'h9a
`endif

//--- rtl/bcdx_pkg.sv
// Purpose: types shared by the execution unit files
// Assumes: bcdx_cfg.svh holds the numbers
// Notes: none
package bcdx_pkg;
	// Instruction request from the decoder
	typedef struct packed {
		logic [7:0] opcode;
		logic [7:0] dst;
		logic [7:0] src;
		logic [7:0] ptr;
		logic [7:0] offset;
		logic [15:0] pc;
		logic [7:0] flags;
		logic sub_before;
	} bcdx_req_t;
	// Results toward register file, flags and program counter
	typedef struct packed {
		logic [7:0] dst_data;
		logic dst_we;
		logic [7:0] ptr_data;
		logic ptr_we;
		logic [7:0] flags;
		logic flags_we;
		logic [15:0] pc;
	} bcdx_res_t;
	typedef enum logic [2:0] {
		BCDX_IDLE = 3'b001,
		BCDX_BUSY = 3'b010,
		BCDX_DONE = 3'b100
	} bcdx_state_t;
endpackage

//--- rtl/bcdx_decadj.sv
// Purpose: combinational decimal adjust correction
// Assumes: byte is the result of a BCD add or subtract
// Notes: non-BCD inputs give an arbitrary but stable value
`timescale 1ns/1ps
`include "bcdx_cfg.svh"
module bcdx_decadj
	import bcdx_pkg::*;
(
	input wire logic [7:0] value,
	input wire logic carry_in,
	input wire logic half_in,
	input wire logic sub_mode,
	output logic [7:0] result,
	output logic carry_out
);
	logic [3:0] hi;
	logic [3:0] lo;
	logic [7:0] corr;
	assign hi = value[7:4];
	assign lo = value[3:0];
	// Correction choice; outside the table falls to no correction
	always_comb
	begin
		corr = 8'h00;
		carry_out = carry_in;
		if (!sub_mode)
		begin
			if (!carry_in && hi <= 4'h8 && !half_in && lo >= 4'ha)
				corr = `BCDX_ADD_06;
			else if (!carry_in && hi <= 4'h9 && half_in && lo <= 4'h3)
				corr = `BCDX_ADD_06;
			else if (!carry_in && hi >= 4'ha && !half_in && lo <= 4'h9)
				corr = `BCDX_ADD_60;
			else if (!carry_in && hi >= 4'h9 && !half_in && lo >= 4'ha)
				corr = `BCDX_ADD_66;
			else if (!carry_in && hi >= 4'ha && half_in && lo <= 4'h3)
				corr = `BCDX_ADD_66;
			else if (carry_in && hi <= 4'h2 && !half_in && lo <= 4'h9)
				corr = `BCDX_ADD_60;
			else if (carry_in && hi <= 4'h2 && !half_in)
				corr = `BCDX_ADD_66;
			else if (carry_in && hi <= 4'h3 && half_in && lo <= 4'h3)
				corr = `BCDX_ADD_66;
			// Carry set whenever the high digit is corrected
			carry_out = carry_in | (corr[7:4] != 4'h0);
		end
		else
		begin
			if (!carry_in && hi <= 4'h8 && half_in && lo >= 4'h6)
				corr = `BCDX_SUB_FA;
			else if (carry_in && hi >= 4'h7 && !half_in && lo <= 4'h9)
				corr = `BCDX_SUB_A0;
			else if (carry_in && hi >= 4'h6 && half_in && lo >= 4'h6)
				corr = `BCDX_SUB_9A;
			// Carry stays as it was before
			carry_out = carry_in;
		end
		result = value + corr;
	end
endmodule

//--- testbench/bcdx_exec_monitor.sv
// Purpose: port checks on the execution unit
// Assumes: one clock, rst synchronous active high
// Notes: bound from tb
`timescale 1ns/1ps
module bcdx_exec_monitor
	import bcdx_pkg::*;
(
	input wire logic clk,
	input wire logic rst,
	input wire logic start,
	input wire bcdx_req_t req,
	input wire logic busy,
	input wire logic done,
	input wire logic illegal,
	input wire bcdx_res_t res
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);
	logic go;
	logic dec;
	logic tk;
	logic ft;
	// Accepted request kinds; a start while busy is ignored by the unit
	assign go = start && !busy;
	assign dec = req.opcode[7:1] == 7'h00;
	assign tk = (req.opcode == 8'hc2 && req.dst == req.src) || (req.opcode == 8'hd2 && req.dst != req.src);
	assign ft = (req.opcode == 8'hc2 || req.opcode == 8'hd2) && !tk;
	dec_time_a: assert property (go && dec |=> (busy && !done)[*2] ##1 done ##1 !busy)
		else $error("decrement timing");
	dec_val_a: assert property (go && dec |=> res.dst_we && res.dst_data == $past(req.dst) - 8'h01)
		else $error("decrement value");
	dec_flag_a: assert property (go && dec |=> res.flags[7] == $past(req.flags[7]) && res.flags[4] == ($past(req.dst) == 8'h80))
		else $error("decrement flags");
	taken_time_a: assert property (go && tk |=> (busy && !done)[*8] ##1 (busy && !done)[*8] ##1 done ##1 !busy)
		else $error("taken branch timing");
	fall_time_a: assert property (go && ft |=> (busy && !done)[*8] ##1 (busy && !done)[*6] ##1 done ##1 !busy)
		else $error("fall through timing");
	ptr_inc_a: assert property (go && (tk || ft) |=> res.ptr_we && !res.flags_we && !res.dst_we && res.ptr_data == $past(req.ptr) + 8'h01)
		else $error("pointer or flag write");
	taken_pc_a: assert property (go && tk |=> res.pc == $past(req.pc) + 16'h0003 + {{8{$past(req.offset[7])}}, $past(req.offset)})
		else $error("taken branch target");
	fall_pc_a: assert property (go && ft |=> res.pc == $past(req.pc) + 16'h0003)
		else $error("fall through address");
	res_hold_a: assert property (busy && $past(busy) |-> $stable(res))
		else $error("result moved while busy");
endmodule

//--- testbench/tb.sv
// Purpose: random and corner tests of the execution unit
// Assumes: 25 ns clock, rst held 8 cycles
// Notes: decimal adjust expected from plain decimal sums and differences
`timescale 1ns/1ps
module tb;
	import bcdx_pkg::*;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic start = 1'b0;
	bcdx_req_t req = '0;
	bcdx_req_t r;
	logic busy;
	logic done;
	logic illegal;
	bcdx_res_t res;
	int miscompares = 0;
	int num_checks = 0;
	int seed = 32'h32c33101;
	int n;
	int i;
	logic [7:0] a;
	logic [7:0] b;
	logic [7:0] s;
	logic [7:0] e;
	logic [7:0] f;
	logic c;
	logic h;
	logic tk;
	bcdx_exec i_bcdx_exec (.clk(clk), .rst(rst), .start(start), .req(req), .busy(busy),
		.done(done), .illegal(illegal), .res(res));
	// Clock
	initial
		forever #12.5 clk = ~clk;
	// Packed BCD to binary and back
	function automatic int dv(input logic [7:0] v);
		return v[7:4] * 10 + v[3:0];
	endfunction
	function automatic logic [7:0] bcd(input int v);
		return 8'((v / 10) * 16 + v % 10);
	endfunction
	task automatic check(input logic [15:0] got, input logic [15:0] exp);
		num_checks++;
		if (got !== exp)
		begin
			miscompares++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	// One request, then count cycles up to done, bounded so a hang cannot stall here
	task automatic go(input bcdx_req_t q);
		@(posedge clk);
		#1 req = q;
		start = 1'b1;
		@(posedge clk);
		#1 start = 1'b0;
		n = 1;
		while (done !== 1'b1 && n < 40)
		begin
			@(posedge clk);
			#1 n++;
		end
	endtask
	task automatic close_out;
		$display("checks %0d mismatches %0d", num_checks, miscompares);
		if (miscompares == 0 && num_checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	// Watchdog, far beyond the few hundred cycles the tests need
	initial
	begin
		#(20000 * 25);
		miscompares++;
		close_out;
	end
	initial
	begin
		repeat (8) @(posedge clk);
		#1 rst = 1'b0;
		// Decrement: wrap, overflow and zero corners first
		for (i = 0; i < 20; i++)
		begin
			a = (i < 4) ? 8'(32'h8000017f >> (8 * i)) : 8'($random(seed));
			f = 8'($random(seed));
			r = '0;
			r.opcode = 8'(i % 2);
			r.dst = a;
			r.flags = f;
			go(r);
			s = a - 8'h01;
			check(16'(n), 16'h0003);
			check(res.dst_data, s);
			check(res.flags[7:2], {f[7], s == 8'h00, s[7], a == 8'h80, f[3:2]});
		end
		$display("test decrement done");
		// Decimal adjust after real BCD add and subtract
		for (i = 0; i < 32; i++)
		begin
			a = (i < 2) ? 8'h15 : bcd({$random(seed)} % 100);
			b = (i < 2) ? 8'h27 : bcd({$random(seed)} % 100);
			r = '0;
			r.flags = 8'($random(seed));
			r.sub_before = i[0];
			r.opcode = 8'h40 | 8'(i[1]);
			{c, s} = i[0] ? {1'b0, a} - {1'b0, b} : {1'b0, a} + {1'b0, b};
			h = i[0] ? a[3:0] < b[3:0] : (a[3:0] + b[3:0]) > 15;
			r.dst = s;
			r.flags[7] = c;
			r.flags[2] = h;
			e = i[0] ? bcd((dv(a) - dv(b) + 100) % 100) : bcd((dv(a) + dv(b)) % 100);
			go(r);
			check(16'(n), 16'h0003);
			check(res.dst_data, e);
			check(res.flags[7:2], {(i[0] ? c : (dv(a) + dv(b) > 99)), e == 8'h00, e[7], r.flags[4:2]});
		end
		$display("test decimal adjust done");
		// Compare forms: both outcomes, offset ends and pointer wrap first
		for (i = 0; i < 24; i++)
		begin
			r = '0;
			r.opcode = i[0] ? 8'hd2 : 8'hc2;
			r.dst = 8'($random(seed));
			r.src = i[1] ? r.dst : r.dst ^ 8'(1 << (i % 8));
			r.ptr = (i < 2) ? 8'hff : 8'($random(seed));
			r.offset = (i < 4) ? 8'(8'h7f + i[0]) : 8'($random(seed));
			r.pc = 16'($random(seed));
			r.flags = 8'($random(seed));
			tk = i[0] ^ i[1];
			go(r);
			check(16'(n), tk ? 16'h0011 : 16'h000f);
			check(res.pc, r.pc + 16'h0003 + (tk ? {{8{r.offset[7]}}, r.offset} : 16'h0000));
			check(res.ptr_data, 8'(r.ptr + 8'h01));
			check({res.dst_we, res.ptr_we, res.flags_we}, 3'b010);
		end
		$display("test compare branch done");
		// Unknown opcode is refused with a pulse and no busy
		r.opcode = 8'h55;
		@(posedge clk);
		#1 req = r;
		start = 1'b1;
		@(posedge clk);
		#1 start = 1'b0;
		check({illegal, busy}, 2'b10);
		$display("test refused opcode done");
		close_out;
	end
endmodule
bind bcdx_exec bcdx_exec_monitor i_bcdx_exec_monitor (.clk(clk), .rst(rst), .start(start),
	.req(req), .busy(busy), .done(done), .illegal(illegal), .res(res));
